// >>> sste_pkg.sv
// Package for the synchronous serial transfer engine: offsets, fields, timing.
package sste_pkg;
	// ==========================================================
	// Register indices on the plain register port
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_TXBUF = 2'h2;
	localparam logic [1:0] ADDR_RXBUF = 2'h3;
	// ==========================================================
	// Control register fields
	localparam int CTRL_START = 7;
	localparam int CTRL_ABORT = 6;
	localparam int CTRL_MODE_LO = 4;
	localparam int CTRL_ORDER = 3;
	localparam int CTRL_CLK_LO = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Transfer mode encodings
	localparam logic [1:0] MODE_TX = 2'h0;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [1:0] MODE_TXRX = 2'h2;
	// Clock source value that selects the external clock
	localparam logic [2:0] CLK_EXT = 3'h7;
	// ==========================================================
	// Status register fields
	localparam int ST_ACTIVE = 7;
	localparam int ST_SHIFT = 6;
	localparam int ST_TXE = 5;
	localparam int ST_RXF = 4;
	localparam int ST_TX_UNDERRUN_FLAG = 3;
	localparam int ST_RX_OVERRUN_FLAG = 2;
	localparam logic [7:0] TXBUF_RESET = 8'hff;
	localparam logic [7:0] RXBUF_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// ==========================================================
	// Half-period of the internal serial clock per clock-source code, in mclk cycles
	localparam int MCLK_HZ = 50000000;
	localparam int HALF_BASE = 2;
	localparam int DIV_W = 12;
endpackage

// >>> sste_engine.sv
// Byte-wide synchronous serial transfer engine with register port and serial pins.
`timescale 1ns/1ps
// ==========================================================
// How it works
// - Bit-order 0 shifts MSB first from Bit7; 1 shifts LSB first from Bit0.
// - Mode 00 is transmit-only, mode 01 is receive-only.
// - A transmit buffer write clears the transmit-buffer-empty flag, unless a load-completing rise or abort sets it that cycle.
// - After start, transfer-active rises on the next serial clock falling edge.
// - Transmit bits leave on serial clock falling edges, in chosen order.
// - Receive bits are sampled on serial clock rising edges, in chosen order.
// - Shift-active is high from a byte's first to eighth falling edge.
// - Buffer-empty sets on a rising edge after load; irq on next falling.
// - Internal clock waits for a buffer write, then loads within one serial cycle.
// - External clock loads the buffer on the first falling edge after start.
// - Internal clock halts high when no new byte; a write resumes shifting.
// - A byte written during shifting follows the previous byte without gap.
// - External clock with no new byte sets underrun at shift start; irq follows.
// - Underrun holds data-out high; software recovers with forced abort.
// - Clearing start finishes the byte, clears transfer-active, leaves data-out high.
// - Forced abort halts at once, clears start, status and both buffers.
// - After eight bits received, byte goes to buffer, full flag and irq set.
// - Internal receive halts clock after each byte until buffer is read.
// - External receive without read sets overrun at shift end, with irq.
// - Overrun discards bits; second read gives shift byte; clearing it clears full.
// - Mode 10 selects combined transmit and receive.
// - Clock code 111 takes the clock from the pin; others drive it out.
// - Stopping leaves error flags; only a zero write or abort clears them.
module sste_engine
	import sste_pkg::*;
(
	input wire logic mclk_in, // System clock, 50 MHz
	input wire logic rst_in, // Synchronous reset, active high
	input wire logic [1:0] addr_in, // Register index
	input wire logic [7:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [7:0] rdata_out, // Read data, one cycle after strobe
	input wire logic sck_in, // Serial clock pin level
	output logic sck_out, // Serial clock drive value
	output logic sck_oe_out, // Serial clock drive enable
	output logic sdo_out, // Serial data out
	input wire logic sdi_in, // Serial data in
	output logic irq_out // Serial interrupt, one-cycle pulse
);
	// ==========================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SHIFT = 2'b10,
		ST_WAIT = 2'b11
	} sste_phase_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic active;
		logic shifting;
		logic txe;
		logic rx_buffer_full_flag;
		logic tx_underrun_flag;
		logic rx_overrun_flag;
		logic [7:0] txbuf;
		logic [7:0] rxbuf;
		logic [7:0] shreg;
		logic [3:0] bitcnt;
		logic tx_loaded;
		logic irq_pend;
		sste_phase_t phase;
		logic [DIV_W-1:0] div;
		logic sck_int;
		logic [1:0] sck_sync;
		logic [1:0] sdi_sync;
		logic sck_prev;
		logic [7:0] rdata;
		logic irq;
		logic sdo;
	} sste_state_t;

	sste_state_t cur_ff;
	sste_state_t nxt_ff;

	logic ext_clk;
	logic [1:0] mode;
	logic lsb_first;
	logic fall;
	logic rise;
	logic tx_on;
	logic rx_on;
	logic [DIV_W-1:0] half_cnt;
	logic in_bit;
	logic in_data;

	// ==========================================================
	// Decode of control fields
	assign ext_clk = (cur_ff.ctrl[CTRL_CLK_LO +: 3] == CLK_EXT);
	assign mode = cur_ff.ctrl[CTRL_MODE_LO +: 2];
	assign lsb_first = cur_ff.ctrl[CTRL_ORDER];
	assign tx_on = (mode == MODE_TX) || (mode == MODE_TXRX);
	assign rx_on = (mode == MODE_RX) || (mode == MODE_TXRX);
	assign in_bit = cur_ff.sck_sync[1];
	assign in_data = cur_ff.sdi_sync[1];

	// Internal half-period doubles for each lower clock-source code
	assign half_cnt = DIV_W'(HALF_BASE) << (3'h6 - cur_ff.ctrl[CTRL_CLK_LO +: 3]);

	// Edge detection on the synchronised pin, or on the internal divider
	always_comb
	begin
		if (ext_clk)
		begin
			fall = cur_ff.sck_prev && !in_bit;
			rise = !cur_ff.sck_prev && in_bit;
		end
		else
		begin
			fall = (cur_ff.div == '0) && cur_ff.sck_int && (cur_ff.phase == ST_SHIFT);
			rise = (cur_ff.div == '0) && !cur_ff.sck_int;
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		logic [7:0] rd_val;
		logic go;
		rd_val = 8'h00;
		go = 1'b0;
		nxt_ff = cur_ff;
		nxt_ff.irq = 1'b0;
		nxt_ff.sck_sync = {cur_ff.sck_sync[0], sck_in}; // Two-flop synchroniser
		nxt_ff.sdi_sync = {cur_ff.sdi_sync[0], sdi_in}; // Data pin is asynchronous too
		nxt_ff.sck_prev = cur_ff.sck_sync[1];

		// Register reads, answered next cycle
		if (rd_in)
		begin
			case (addr_in)
				ADDR_CTRL: rd_val = cur_ff.ctrl;
				ADDR_STATUS: rd_val = {cur_ff.active, cur_ff.shifting, cur_ff.txe, cur_ff.rx_buffer_full_flag,
					cur_ff.tx_underrun_flag, cur_ff.rx_overrun_flag, 2'b00};
				ADDR_RXBUF:
				begin
					rd_val = cur_ff.rxbuf;
					// A repeat read during overrun returns the held shift byte
					if (cur_ff.rx_overrun_flag)
					begin
						nxt_ff.rxbuf = cur_ff.shreg;
					end
					else
					begin
						nxt_ff.rx_buffer_full_flag = 1'b0;
					end
				end
				default: rd_val = 8'h00;
			endcase
		end
		nxt_ff.rdata = rd_val;

		// Register writes
		if (wr_in)
		begin
			case (addr_in)
				ADDR_CTRL: nxt_ff.ctrl = wdata_in;
				ADDR_STATUS:
				begin
					// Error flags clear only on a zero write
					if (!wdata_in[ST_TX_UNDERRUN_FLAG])
					begin
						nxt_ff.tx_underrun_flag = 1'b0;
					end
					if (!wdata_in[ST_RX_OVERRUN_FLAG] && cur_ff.rx_overrun_flag)
					begin
						nxt_ff.rx_overrun_flag = 1'b0;
						nxt_ff.rx_buffer_full_flag = 1'b0;
					end
				end
				ADDR_TXBUF:
				begin
					nxt_ff.txbuf = wdata_in;
					nxt_ff.txe = 1'b0;
				end
				default: ;
			endcase
		end

		// Internal clock divider runs only while shifting
		if (!ext_clk && cur_ff.phase == ST_SHIFT)
		begin
			nxt_ff.div = (cur_ff.div == '0) ? half_cnt - DIV_W'(1) : cur_ff.div - DIV_W'(1);
			if (cur_ff.div == '0)
			begin
				nxt_ff.sck_int = !cur_ff.sck_int;
			end
		end
		else
		begin
			nxt_ff.div = '0;
			nxt_ff.sck_int = 1'b1; // Halts high while waiting
		end

		// Sequencer
		case (cur_ff.phase)
			ST_IDLE:
			begin
				nxt_ff.active = 1'b0;
				if (cur_ff.ctrl[CTRL_START])
				begin
					nxt_ff.phase = ST_LOAD;
				end
			end
			ST_LOAD, ST_WAIT:
			begin
				// Internal clock waits for data or for the reader; external starts on the edge
				if (!cur_ff.ctrl[CTRL_START] && cur_ff.phase == ST_WAIT)
				begin
					nxt_ff.phase = ST_IDLE;
					nxt_ff.sdo = 1'b1;
				end
				else if (ext_clk)
				begin
					go = fall;
				end
				else
				begin
					go = (!tx_on || !cur_ff.txe) && (!rx_on || !cur_ff.rx_buffer_full_flag);
				end
			end
			ST_SHIFT:
			begin
				if (fall)
				begin
					if (cur_ff.bitcnt == BITS_PER_BYTE)
					begin
						nxt_ff.shifting = 1'b0;
						if (!cur_ff.ctrl[CTRL_START])
						begin
							nxt_ff.phase = ST_IDLE;
							nxt_ff.active = 1'b0;
							nxt_ff.sdo = 1'b1;
						end
						else if (ext_clk || ((!tx_on || !cur_ff.txe) && (!rx_on || !cur_ff.rx_buffer_full_flag)))
						begin
							go = 1'b1;
						end
						else
						begin
							nxt_ff.phase = ST_WAIT;
							nxt_ff.sck_int = 1'b1; // No low glitch on entering the wait
							nxt_ff.div = '0;
						end
					end
					else
					begin
						// Next bit out on the falling edge
						nxt_ff.shifting = (cur_ff.bitcnt != BITS_PER_BYTE - 4'h1);
						nxt_ff.sdo = cur_ff.tx_underrun_flag || !tx_on ? 1'b1 :
							(lsb_first ? cur_ff.shreg[0] : cur_ff.shreg[7]);
						if (!rx_on)
						begin
							nxt_ff.shreg = lsb_first ? {1'b1, cur_ff.shreg[7:1]} : {cur_ff.shreg[6:0], 1'b1};
						end
					end
				end
				if (rise)
				begin
					// Load completion marks the buffer empty, irq waits for the next fall
					if (cur_ff.tx_loaded)
					begin
						nxt_ff.tx_loaded = 1'b0;
						nxt_ff.txe = 1'b1;
						nxt_ff.irq_pend = 1'b1;
					end
					if (rx_on && !cur_ff.rx_overrun_flag)
					begin
						// Sample on the rising edge
						nxt_ff.shreg = lsb_first ? {in_data, cur_ff.shreg[7:1]} : {cur_ff.shreg[6:0], in_data};
					end
					else if (rx_on && tx_on)
					begin
						nxt_ff.shreg = lsb_first ? {1'b1, cur_ff.shreg[7:1]} : {cur_ff.shreg[6:0], 1'b1};
					end
					nxt_ff.bitcnt = cur_ff.bitcnt + 4'h1;
					if (cur_ff.bitcnt == BITS_PER_BYTE - 4'h1 && rx_on && !cur_ff.rx_overrun_flag)
					begin
						if (cur_ff.rx_buffer_full_flag && ext_clk)
						begin
							nxt_ff.rx_overrun_flag = 1'b1;
							nxt_ff.irq = 1'b1;
						end
						else
						begin
							nxt_ff.rxbuf = lsb_first ? {in_data, cur_ff.shreg[7:1]} : {cur_ff.shreg[6:0], in_data};
							nxt_ff.rx_buffer_full_flag = 1'b1;
							nxt_ff.irq = 1'b1;
						end
					end
				end
				if (fall && cur_ff.irq_pend)
				begin
					nxt_ff.irq_pend = 1'b0;
					nxt_ff.irq = 1'b1;
				end
				// Clearing start after the eighth sample ends the byte without another edge
				if (cur_ff.bitcnt == BITS_PER_BYTE && !cur_ff.ctrl[CTRL_START])
				begin
					nxt_ff.phase = ST_IDLE;
					nxt_ff.active = 1'b0;
					nxt_ff.sdo = 1'b1;
					nxt_ff.sck_int = 1'b1;
					nxt_ff.div = '0;
				end
			end
			default: nxt_ff.phase = ST_IDLE;
		endcase

		// Start of a byte: load the shift register and drive its first bit
		if (go)
		begin
			nxt_ff.phase = ST_SHIFT;
			nxt_ff.active = 1'b1;
			nxt_ff.shifting = 1'b1;
			nxt_ff.bitcnt = 4'h0;
			if (tx_on)
			begin
				if (cur_ff.txe && ext_clk)
				begin
					nxt_ff.tx_underrun_flag = 1'b1;
					nxt_ff.irq_pend = 1'b1;
					nxt_ff.sdo = 1'b1;
				end
				else
				begin
					nxt_ff.shreg = rx_on ? cur_ff.txbuf :
						(lsb_first ? {1'b1, cur_ff.txbuf[7:1]} : {cur_ff.txbuf[6:0], 1'b1});
					nxt_ff.sdo = cur_ff.tx_underrun_flag ? 1'b1 : (lsb_first ? cur_ff.txbuf[0] : cur_ff.txbuf[7]);
					nxt_ff.tx_loaded = 1'b1;
				end
			end
			if (!ext_clk)
			begin
				nxt_ff.sck_int = 1'b0;
				nxt_ff.div = half_cnt - DIV_W'(1);
			end
		end

		// Forced abort halts at once and clears everything it owns
		if (cur_ff.ctrl[CTRL_ABORT])
		begin
			nxt_ff.ctrl[CTRL_START] = 1'b0;
			nxt_ff.ctrl[CTRL_ABORT] = 1'b0;
			nxt_ff.active = 1'b0;
			nxt_ff.shifting = 1'b0;
			nxt_ff.txe = 1'b1;
			nxt_ff.rx_buffer_full_flag = 1'b0;
			nxt_ff.tx_underrun_flag = 1'b0;
			nxt_ff.rx_overrun_flag = 1'b0;
			nxt_ff.txbuf = TXBUF_RESET;
			nxt_ff.rxbuf = RXBUF_RESET;
			nxt_ff.tx_loaded = 1'b0;
			nxt_ff.irq_pend = 1'b0;
			nxt_ff.phase = ST_IDLE;
			nxt_ff.sck_int = 1'b1;
			nxt_ff.sdo = 1'b1;
			nxt_ff.irq = 1'b0;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			cur_ff <= '0;
			cur_ff.ctrl <= CTRL_RESET;
			cur_ff.txe <= 1'b1;
			cur_ff.txbuf <= TXBUF_RESET;
			cur_ff.rxbuf <= RXBUF_RESET;
			cur_ff.phase <= ST_IDLE;
			cur_ff.sck_int <= 1'b1;
			cur_ff.sck_sync <= 2'b11;
			cur_ff.sck_prev <= 1'b1;
			cur_ff.sdo <= 1'b1;
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata_out = cur_ff.rdata;
	assign sck_out = cur_ff.sck_int;
	assign sck_oe_out = !ext_clk;
	assign sdo_out = cur_ff.sdo;
	assign irq_out = cur_ff.irq;
endmodule

// >>> sste_chk.sv
// Port-level timing checks for the serial transfer engine.
`timescale 1ns/1ps
module sste_chk
	import sste_pkg::*;
(
	input wire logic mclk_in, // Clock
	input wire logic rst_in, // Reset
	input wire logic [1:0] addr_in, // Register index
	input wire logic [7:0] wdata_in, // Write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	input wire logic [7:0] rdata_out, // Read data
	input wire logic sck_in, // Clock pin
	input wire logic sck_out, // Clock drive
	input wire logic sck_oe_out, // Clock enable
	input wire logic sdo_out, // Data out
	input wire logic sdi_in, // Data in
	input wire logic irq_out // Interrupt
);
	logic [2:0] clk_code_ff; // Clock source as last written
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Shadow of the clock field; abort leaves it alone
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			clk_code_ff <= 3'h0;
		else if (wr_in && addr_in == ADDR_CTRL)
			clk_code_ff <= wdata_in[2:0];
	end
	// ==========================================================
	// Assertions
	AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside its slot");
	AST_RESET_IDLE: assert property ($fell(rst_in) |-> sck_out && sdo_out && !irq_out)
		else $error("pins not idle after reset");
	AST_CLK_DIR: assert property (sck_oe_out == (clk_code_ff != CLK_EXT))
		else $error("clock pin direction wrong");
	AST_IRQ_PULSE: assert property (irq_out |=> !irq_out)
		else $error("interrupt longer than a pulse");
	AST_ABORT: assert property (wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_ABORT] |-> ##[1:3] (sck_out && sdo_out))
		else $error("abort did not halt the pins");
	AST_SDO_EDGE: assert property (sck_oe_out && $rose(sck_out) |-> $stable(sdo_out))
		else $error("data out moved on a rising edge");
	AST_LOW_HALF: assert property (sck_oe_out && clk_code_ff == 3'h5 && $fell(sck_out) |=> !sck_out [*3] ##1 sck_out)
		else $error("low half period wrong");
	AST_HIGH_HALF: assert property (sck_oe_out && clk_code_ff == 3'h5 && $rose(sck_out) |=> sck_out [*3])
		else $error("high half period too short");
endmodule
bind sste_engine sste_chk chk_u (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sck_in(sck_in), .sck_out(sck_out),
	.sck_oe_out(sck_oe_out), .sdo_out(sdo_out), .sdi_in(sdi_in), .irq_out(irq_out));

// >>> sste_peer.sv
// External serial device: shifts a byte in and out, can supply the clock.
`timescale 1ns/1ps
module sste_peer (
	input wire logic clk_in, // System clock
	input wire logic sck_in, // Resolved clock pin
	input wire logic sdo_in, // Engine data out
	output logic sdi_out, // Data toward the engine
	output logic sck_out // Clock supplied in external mode
);
	logic [7:0] tx_sr = 8'h00; // Byte to send, first bit at the top
	logic [7:0] cap_sr = 8'h00; // Last eight bits seen
	logic last_sck = 1'b1;
	int rises = 0;
	initial sdi_out = 1'b1;
	initial sck_out = 1'b1;
	// Drive on falling pin edges, capture on rising; a spent line keeps toggling
	always @(posedge clk_in)
	begin
		last_sck <= sck_in;
		if (last_sck && !sck_in)
		begin
			sdi_out <= tx_sr[7];
			tx_sr <= {tx_sr[6:0], ~tx_sr[0]};
		end
		if (!last_sck && sck_in)
		begin
			cap_sr <= {cap_sr[6:0], sdo_in};
			rises <= rises + 1;
		end
	end
	task automatic load(input logic [7:0] b);
		tx_sr = b;
		rises = 0;
	endtask
	// Eight clock pulses, wide enough for the engine's synchroniser
	task automatic frame(input int half);
		repeat (8)
		begin
			repeat (half) @(posedge clk_in);
			sck_out <= 1'b0;
			repeat (half) @(posedge clk_in);
			sck_out <= 1'b1;
		end
		repeat (half) @(posedge clk_in);
	endtask
endmodule

// >>> sste_engine_tb.sv
// Self-checking bench for the serial transfer engine.
`timescale 1ns/1ps
module sste_engine_tb;
	import sste_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00;
	logic [7:0] rdata_out, rv, d, e, c;
	logic sck_out, sck_oe_out, sdo_out, irq_out, sdi, peer_sck, sck_pin;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	// Engine drives the pin unless the external source is chosen
	assign sck_pin = sck_oe_out ? sck_out : peer_sck;
	always #10 mclk_in = ~mclk_in;
	sste_engine dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
		.sdo_out(sdo_out), .sdi_in(sdi), .irq_out(irq_out));
	sste_peer peer_u (.clk_in(mclk_in), .sck_in(sck_pin), .sdo_in(sdo_out), .sdi_out(sdi), .sck_out(peer_sck));
	task automatic final_report;
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard, far above the roughly one thousand cycles needed
	always @(posedge mclk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			mismatches++;
			final_report();
		end
	end
	function automatic logic [7:0] wire_order(input logic [7:0] b, input logic lsb);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = b[7 - i];
		return lsb ? r : b;
	endfunction
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 rv = rdata_out;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	// ==========================================================
	// Sequence
	initial
	begin
		void'($urandom(32'h1f09));
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Every mode in both orders; code 5 leaves the data-in synchroniser time to settle
		for (int m = 0; m < 3; m++)
			for (int o = 0; o < 2; o++)
			begin
				d = $urandom;
				e = $urandom;
				c = {2'h0, m[1:0], o[0], 3'h5};
				peer_u.load(e);
				wr(ADDR_CTRL, c);
				if (m != 1)
					wr(ADDR_TXBUF, d);
				wr(ADDR_CTRL, c | 8'h80);
				wait (peer_u.rises >= 8);
				wr(ADDR_CTRL, c);
				for (int i = 0; i < 60; i++)
				begin
					rd(ADDR_STATUS);
					if (rv[ST_ACTIVE] !== 1'b1)
						break;
				end
				chk("active", 8'h00, rv & 8'h80);
				if (m != 1)
				begin
					chk("tx_bits", wire_order(d, o[0]), peer_u.cap_sr);
					chk("sdo_idle", 8'h01, {7'h0, sdo_out});
				end
				if (m != 0)
				begin
					rd(ADDR_RXBUF);
					chk("rx_byte", wire_order(e, o[0]), rv);
					rd(ADDR_STATUS);
					chk("rx_full", 8'h00, rv & 8'h10);
				end
			end
		// External clock with nothing queued, then stop and abort
		wr(ADDR_CTRL, 8'h87);
		peer_u.frame(8);
		chk("sdo_hold", 8'hff, peer_u.cap_sr);
		wr(ADDR_CTRL, 8'h07);
		rd(ADDR_STATUS);
		chk("underrun", 8'h08, rv & 8'h88);
		wr(ADDR_CTRL, 8'h47);
		rd(ADDR_STATUS);
		chk("abort_status", 8'h00, rv & 8'hcc);
		// External receive, two bytes with no read between
		peer_u.load(d);
		wr(ADDR_CTRL, 8'h97);
		peer_u.frame(8);
		peer_u.load(e);
		peer_u.frame(8);
		wr(ADDR_CTRL, 8'h17);
		rd(ADDR_STATUS);
		chk("overrun", 8'h04, rv & 8'h04);
		rd(ADDR_RXBUF);
		chk("rx_first", d, rv);
		rd(ADDR_RXBUF);
		chk("rx_second", e, rv);
		final_report();
	end
endmodule
